// ===== rtl/ebma_arbiter.sv
`timescale 1ns/1ns
module ebma_arbiter (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           bus_request_n,
    input  wire logic                           addr_strobe_n,
    input  wire logic                           rw_n,
    input  wire logic [ebma_pkg::ADDR_W-1:0]    ext_addr,
    input  wire logic [ebma_pkg::DATA_W-1:0]    ext_data_in,
    input  wire logic                           core_cycle_busy,
    input  wire logic                           graphics_dma_engine_request,
    input  wire logic                           dram_hit,
    input  wire logic                           chipsel_hit,
    input  wire logic                           reg_hit,
    input  wire logic                           tgt_done,
    input  wire logic                           cs_rd_release,
    input  wire logic [ebma_pkg::DATA_W-1:0]    tgt_rdata,
    input  wire logic                           sw_clear_illegal,
    output logic                                bus_grant_n,
    output logic                                ext_transfer_ack_n,
    output logic                                bus_float,
    output logic                                core_owns_bus,
    output logic                                graphics_dma_engine_grant,
    output logic [ebma_pkg::DATA_W-1:0]         ext_data_out,
    output logic                                ext_data_oe,
    output logic                                tgt_start,
    output logic                                tgt_write,
    output logic [1:0]                          tgt_select,
    output logic [ebma_pkg::DATA_W-1:0]         tgt_wdata,
    output logic                                ext_illegal_addr_flag,
    output logic [2:0]                          event_level
);
    ebma_xfer_if xf ();

    ebma_turn_timer u_turn (
        .clk           (clk),
        .rst           (rst),
        .xf            (xf),
        .tgt_done      (tgt_done),
        .cs_rd_release (cs_rd_release),
        .tgt_rdata     (tgt_rdata)
    );

    // pin synchronisers
    logic [1:0] br_sync_ff;
    logic [1:0] as_sync_ff;
    logic [1:0] rw_sync_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            br_sync_ff <= 2'h0;
            as_sync_ff <= 2'h0;
            rw_sync_ff <= 2'h0;
        end else begin
            br_sync_ff <= {br_sync_ff[0], ~bus_request_n};
            as_sync_ff <= {as_sync_ff[0], ~addr_strobe_n};
            rw_sync_ff <= {rw_sync_ff[0], rw_n};
        end
    end
    logic br_req;
    logic as_act;
    logic rw_rd;
    assign br_req = br_sync_ff[1];
    assign as_act = as_sync_ff[1];
    assign rw_rd  = rw_sync_ff[1];

    // address sampled only once strobe is synchronised; master holds it stable
    logic [1:0] decode;
    always_comb begin
        decode = ebma_pkg::TGT_NONE;
        // a 25-bit word address spans exactly the lowest 64M
        if (reg_hit) begin
            decode = ebma_pkg::TGT_REG;
        end else if (chipsel_hit) begin
            decode = ebma_pkg::TGT_CHIPSEL;
        end else if (dram_hit) begin
            decode = ebma_pkg::TGT_DRAM;
        end
    end

    ebma_pkg::ebma_state_type state_ff;
    ebma_pkg::ebma_state_type nxt_state;
    logic                     illegal_ff;
    logic                     turn_ff;
    logic                     graphics_dma_engine_last_ff;
    logic                     as_seen_ff;

    wire start_cycle = (state_ff == ebma_pkg::ST_GRANTED) && as_act && !as_seen_ff && !(graphics_dma_engine_request && !graphics_dma_engine_last_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ebma_pkg::ST_CORE: begin
                if (br_req && !core_cycle_busy) begin
                    nxt_state = ebma_pkg::ST_FLOAT;
                end
            end
            ebma_pkg::ST_FLOAT: begin
                nxt_state = ebma_pkg::ST_GRANTED;
            end
            ebma_pkg::ST_GRANTED: begin
                if (!br_req && !as_act) begin
                    nxt_state = ebma_pkg::ST_CORE;
                end else if (start_cycle) begin
                    nxt_state = (decode == ebma_pkg::TGT_NONE) ? ebma_pkg::ST_ACK : ebma_pkg::ST_ACCESS;
                end
            end
            ebma_pkg::ST_ACCESS: begin
                if (xf.done) begin
                    nxt_state = (!rw_rd) ? ebma_pkg::ST_ACK : ebma_pkg::ST_TURN;
                end
            end
            ebma_pkg::ST_TURN: begin
                if (xf.turn_done) begin
                    nxt_state = ebma_pkg::ST_ACK;
                end
            end
            ebma_pkg::ST_ACK: begin
                if (!as_act) begin
                    nxt_state = ebma_pkg::ST_GRANTED;
                end
            end
            default: nxt_state = ebma_pkg::ST_CORE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ebma_pkg::ST_CORE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // a strobe already active when a cycle ends must drop before the next
    always_ff @(posedge clk) begin
        if (rst) begin
            as_seen_ff <= 1'b0;
        end else if (start_cycle) begin
            as_seen_ff <= 1'b1;
        end else if (!as_act) begin
            as_seen_ff <= 1'b0;
        end
    end

    // alternate turns with graphics dma
    always_ff @(posedge clk) begin
        if (rst) begin
            graphics_dma_engine_last_ff <= 1'b0;
            graphics_dma_engine_grant   <= 1'b0;
        end else begin
            graphics_dma_engine_grant <= graphics_dma_engine_request && (state_ff == ebma_pkg::ST_GRANTED) && !start_cycle;
            if (start_cycle) begin
                graphics_dma_engine_last_ff <= 1'b0;
            end else if (graphics_dma_engine_grant) begin
                graphics_dma_engine_last_ff <= 1'b1;
            end
        end
    end

    // bus ownership pins
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_grant_n   <= 1'b1;
            bus_float     <= 1'b0;
            core_owns_bus <= 1'b1;
        end else begin
            bus_float     <= (nxt_state != ebma_pkg::ST_CORE);
            core_owns_bus <= (nxt_state == ebma_pkg::ST_CORE);
            bus_grant_n   <= !((nxt_state != ebma_pkg::ST_CORE) && (state_ff != ebma_pkg::ST_CORE));
        end
    end

    // target access control; dram runs from its own controller regardless
    always_ff @(posedge clk) begin
        if (rst) begin
            tgt_start  <= 1'b0;
            tgt_write  <= 1'b0;
            tgt_select <= 2'h0;
            tgt_wdata  <= 16'h0000;
        end else begin
            tgt_start <= start_cycle && (decode != ebma_pkg::TGT_NONE);
            if (start_cycle) begin
                tgt_write  <= !rw_rd;
                tgt_select <= decode;
                tgt_wdata  <= ext_data_in;
            end
        end
    end

    assign xf.start      = tgt_start;
    assign xf.write      = tgt_write;
    assign xf.target     = tgt_select;
    assign xf.turn_start = (state_ff == ebma_pkg::ST_ACCESS) && xf.done && rw_rd;

    // acknowledge and read data drive
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_transfer_ack_n <= 1'b1;
            ext_data_oe        <= 1'b0;
            ext_data_out       <= 16'h0000;
            turn_ff            <= 1'b0;
        end else begin
            ext_transfer_ack_n <= !(nxt_state == ebma_pkg::ST_ACK);
            turn_ff            <= (nxt_state == ebma_pkg::ST_ACK) && (state_ff == ebma_pkg::ST_TURN);
            if ((nxt_state == ebma_pkg::ST_ACK) && (state_ff == ebma_pkg::ST_TURN)) begin
                ext_data_oe  <= 1'b1;
                ext_data_out <= xf.rdata;
            end else if (nxt_state != ebma_pkg::ST_ACK) begin
                ext_data_oe  <= 1'b0;
            end
        end
    end

    // illegal access flag, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_ff            <= 1'b0;
            ext_illegal_addr_flag <= 1'b0;
            event_level           <= 3'h0;
        end else begin
            if (start_cycle && decode == ebma_pkg::TGT_NONE) begin
                illegal_ff <= 1'b1;
            end else if (sw_clear_illegal) begin
                illegal_ff <= 1'b0;
            end
            ext_illegal_addr_flag <= illegal_ff;
            event_level           <= illegal_ff ? ebma_pkg::EVENT_LEVEL : 3'h0;
        end
    end

    // protocol checks
    AST_ONE_MASTER: assert property (@(posedge clk) disable iff (rst)
        !(core_owns_bus && !bus_grant_n))
        else $error("core and external both own bus");

    AST_FLOAT_FIRST: assert property (@(posedge clk) disable iff (rst)
        $fell(bus_grant_n) |-> $past(bus_float))
        else $error("grant before float");

    AST_RESET_STATE: assert property (@(posedge clk)
        $past(rst) |-> bus_grant_n && core_owns_bus)
        else $error("bad reset state");

    AST_ACK_HOLD: assert property (@(posedge clk) disable iff (rst)
        (!ext_transfer_ack_n && as_act)
        |=> !ext_transfer_ack_n)
        else $error("ack dropped early");

    AST_GRANT_OVER_ACK: assert property (@(posedge clk) disable iff (rst)
        !ext_transfer_ack_n |-> !bus_grant_n)
        else $error("grant lost during ack");

    AST_ILLEGAL_ACK: assert property (@(posedge clk) disable iff (rst)
        (start_cycle && decode == ebma_pkg::TGT_NONE)
        |=> ##1 !ext_transfer_ack_n)
        else $error("unmapped not acked");

    AST_ILLEGAL_FLAG: assert property (@(posedge clk) disable iff (rst)
        (start_cycle && decode == ebma_pkg::TGT_NONE)
        |=> ##1 event_level == 3'h7)
        else $error("no level 7 event");

    AST_CLEAR_ONLY_SW: assert property (@(posedge clk) disable iff (rst)
        $fell(illegal_ff) |-> $past(sw_clear_illegal))
        else $error("flag cleared without write");

    AST_WRITE_AFTER_DONE: assert property (@(posedge clk) disable iff (rst)
        ($fell(ext_transfer_ack_n) && tgt_write && $past(state_ff) == ebma_pkg::ST_ACCESS)
        |-> $past(tgt_done))
        else $error("write ack before target done");

    AST_READ_DATA_DRIVEN: assert property (@(posedge clk) disable iff (rst)
        ($fell(ext_transfer_ack_n) && turn_ff)
        |-> ext_data_oe)
        else $error("read ack without data");

    AST_GRAPHICS_DMA_ENGINE_TURN: assert property (@(posedge clk) disable iff (rst)
        !(graphics_dma_engine_grant && tgt_start))
        else $error("graphics_dma_engine and external overlap");

    AST_TURN_WAIT: assert property (@(posedge clk) disable iff (rst)
        xf.turn_start
        |=> ext_transfer_ack_n [*3] ##1 !ext_transfer_ack_n)
        else $error("read data driven before turnaround");

    AST_UNMAPPED_NO_START: assert property (@(posedge clk) disable iff (rst)
        (start_cycle && decode == ebma_pkg::TGT_NONE) |=> !tgt_start)
        else $error("unmapped access reached a target");

    AST_FLAG_EVENT: assert property (@(posedge clk) disable iff (rst)
        ext_illegal_addr_flag |-> event_level == ebma_pkg::EVENT_LEVEL)
        else $error("flag without level 7 event");

    AST_CORE_STATE: assert property (@(posedge clk) disable iff (rst)
        core_owns_bus == (state_ff == ebma_pkg::ST_CORE))
        else $error("core ownership out of step");

    AST_OE_WITH_ACK: assert property (@(posedge clk) disable iff (rst)
        ext_data_oe |-> !ext_transfer_ack_n)
        else $error("data driven without ack");

    AST_WRITE_NO_DRIVE: assert property (@(posedge clk) disable iff (rst)
        (!ext_transfer_ack_n && tgt_write) |-> !ext_data_oe)
        else $error("data driven during write ack");

    AST_GRANT_FLOATED: assert property (@(posedge clk) disable iff (rst)
        !bus_grant_n |-> bus_float)
        else $error("grant while pins driven");
endmodule

// ===== rtl/ebma_pkg.sv
// Summary of operation
// - Only one bus master at a time: core or granted external master.
// - External master reaches only the lowest 64M; higher addresses are unmapped.
// - Graphics DMA and external master alternate cycles when both want the bus.
// - Float address, data, strobe and direction before asserting grant.
// - External master drives controls; device acknowledges the end of each cycle.
// - Request may arrive mid-cycle or between cycles; grant once bus is free.
// - Drop returns bus to core; early drop holds grant until ack ends.
// - DRAM accesses and refresh go on regardless of bus owner.
// - Reads: capture target data, then drive it and acknowledge.
// - Chip-select reads capture on strobe-release edge; drive after turnaround hold.
// - Read data valid while acknowledge asserted; master then drops strobe.
// - Writes pass data straight to target; acknowledge after target completes.
// - Unmapped access: acknowledge at once, hold until address strobe drops.
// - Unmapped access sets illegal-address flag and posts a level 7 event.
// - Illegal-address flag clears only by software writing a one.
package ebma_pkg;

    localparam int         ADDR_W         = 25;
    localparam int         DATA_W         = 16;
    localparam int         REACH_MSB      = 25;
    localparam int         CLK_PERIOD_NS  = 4;
    localparam int         TURN_HOLD_NS   = 10;
    localparam int         TURN_CYC       = (TURN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] EVENT_LEVEL    = 3'h7;
    localparam logic [1:0] TGT_NONE       = 2'h0;
    localparam logic [1:0] TGT_DRAM       = 2'h1;
    localparam logic [1:0] TGT_CHIPSEL    = 2'h2;
    localparam logic [1:0] TGT_REG        = 2'h3;

    typedef enum logic [2:0] {
        ST_CORE    = 3'h0,
        ST_FLOAT   = 3'h1,
        ST_GRANTED = 3'h2,
        ST_ACCESS  = 3'h3,
        ST_TURN    = 3'h4,
        ST_ACK     = 3'h5
    } ebma_state_type;

endpackage

// ===== rtl/ebma_xfer_if.sv
`timescale 1ns/1ns
interface ebma_xfer_if;
    logic                           start;
    logic                           write;
    logic [1:0]                     target;
    logic                           done;
    logic [ebma_pkg::DATA_W-1:0]    rdata;
    logic                           cs_strobe_release;
    logic                           turn_done;
    logic                           turn_start;
    modport arb  (output start, output write, output target, output turn_start,
                  input done, input rdata, input cs_strobe_release, input turn_done);
    modport path (input start, input write, input target, input turn_start,
                  output done, output rdata, output cs_strobe_release, output turn_done);
endinterface

// ===== rtl/ebma_turn_timer.sv
`timescale 1ns/1ns
module ebma_turn_timer (
    input  wire logic   clk,
    input  wire logic   rst,
    ebma_xfer_if.path   xf,
    input  wire logic   tgt_done,
    input  wire logic   cs_rd_release,
    input  wire logic [ebma_pkg::DATA_W-1:0] tgt_rdata
);
    logic [3:0]                     cnt_ff;
    logic [ebma_pkg::DATA_W-1:0]    rdata_ff;

    // capture the target word at the end of its access
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (!xf.write && ((xf.target == ebma_pkg::TGT_CHIPSEL) ? cs_rd_release : tgt_done)) begin
            rdata_ff <= tgt_rdata;
        end
    end

    // turnaround hold before the device drives read data
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 4'h0;
        end else if (xf.turn_start) begin
            cnt_ff <= 4'(ebma_pkg::TURN_CYC);
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    assign xf.done              = tgt_done;
    assign xf.rdata             = rdata_ff;
    assign xf.cs_strobe_release = cs_rd_release;
    assign xf.turn_done         = (cnt_ff == 4'h1);
endmodule

// ===== dv/ebma_ext_master.sv
`timescale 1ns/1ns
module ebma_ext_master (
    input  wire logic                        clk,
    input  wire logic                        bus_grant_n,
    input  wire logic                        ext_transfer_ack_n,
    input  wire logic [ebma_pkg::DATA_W-1:0] ext_data_out,
    output logic                             bus_request_n,
    output logic                             addr_strobe_n,
    output logic                             rw_n,
    output logic [ebma_pkg::ADDR_W-1:0]      ext_addr,
    output logic [ebma_pkg::DATA_W-1:0]      ext_data_in
);
    initial begin
        bus_request_n = 1'b1;
        addr_strobe_n = 1'b1;
        rw_n          = 1'b1;
        ext_addr      = '0;
        ext_data_in   = '0;
    end

    // one word cycle per call, request dropped afterwards, or with the strobe when early
    task automatic run(input logic wr, input logic [ebma_pkg::ADDR_W-1:0] a,
                       input logic [ebma_pkg::DATA_W-1:0] d, input logic early, input int hold,
                       output logic [ebma_pkg::DATA_W-1:0] rd, output logic ackh, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        bus_request_n = 1'b0;
        while (bus_grant_n !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 200);
        @(negedge clk);
        ext_addr      = a;
        rw_n          = !wr;
        ext_data_in   = d;
        addr_strobe_n = 1'b0;
        if (early)
            bus_request_n = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ext_transfer_ack_n !== 1'b0 && n < 200);
        rd = ext_data_out;
        ok = ok && (n < 200);
        ackh = ext_transfer_ack_n;
        repeat (hold) begin
            @(posedge clk);
            ackh = ext_transfer_ack_n;
        end
        @(negedge clk);
        addr_strobe_n = 1'b1;
        bus_request_n = 1'b1;
        ext_addr      = ~a;
        ext_data_in   = ~d;
        rw_n          = wr;
    endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0, rst, bus_request_n, addr_strobe_n, rw_n, core_cycle_busy = 1'b0, graphics_dma_engine_request = 1'b0;
    logic        tgt_done = 1'b0, cs_rd_release = 1'b0, sw_clear_illegal, bus_grant_n, ext_transfer_ack_n;
    logic        bus_float, core_owns_bus, graphics_dma_engine_grant, ext_data_oe, tgt_start, tgt_write;
    logic        ext_illegal_addr_flag, cur_wr;
    logic [24:0] ext_addr, cur_addr;
    logic [15:0] ext_data_in, ext_data_out, tgt_rdata = 16'h0000, tgt_wdata, cur_wdata;
    logic [1:0]  tgt_select;
    logic [2:0]  event_level;
    int          miscompares, check_count, cycles, tgt_cnt = 0;

    ebma_arbiter u_ebma_arbiter (.clk(clk), .rst(rst), .bus_request_n(bus_request_n),
        .addr_strobe_n(addr_strobe_n), .rw_n(rw_n), .ext_addr(ext_addr), .ext_data_in(ext_data_in),
        .core_cycle_busy(core_cycle_busy), .graphics_dma_engine_request(graphics_dma_engine_request),
        .dram_hit(region(ext_addr) == ebma_pkg::TGT_DRAM), .chipsel_hit(region(ext_addr) == ebma_pkg::TGT_CHIPSEL),
        .reg_hit(region(ext_addr) == ebma_pkg::TGT_REG), .tgt_done(tgt_done), .cs_rd_release(cs_rd_release),
        .tgt_rdata(tgt_rdata), .sw_clear_illegal(sw_clear_illegal), .bus_grant_n(bus_grant_n),
        .ext_transfer_ack_n(ext_transfer_ack_n), .bus_float(bus_float), .core_owns_bus(core_owns_bus),
        .graphics_dma_engine_grant(graphics_dma_engine_grant), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .tgt_start(tgt_start), .tgt_write(tgt_write), .tgt_select(tgt_select), .tgt_wdata(tgt_wdata),
        .ext_illegal_addr_flag(ext_illegal_addr_flag), .event_level(event_level));

    ebma_ext_master u_ebma_ext_master (.clk(clk), .bus_grant_n(bus_grant_n),
        .ext_transfer_ack_n(ext_transfer_ack_n), .ext_data_out(ext_data_out),
        .bus_request_n(bus_request_n), .addr_strobe_n(addr_strobe_n), .rw_n(rw_n),
        .ext_addr(ext_addr), .ext_data_in(ext_data_in));

    function automatic logic [1:0] region(input logic [24:0] a);
        if (a[24] || a[23:22] == 2'h3)
            return ebma_pkg::TGT_NONE;
        return a[23:22] + 2'h1;
    endfunction

    function automatic logic [15:0] exp_rd(input logic [24:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("mismatches %0d of %0d checks", miscompares, check_count);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always #2 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            stop_test;
        end
    end

    // target with random latency, plus core and graphics dma traffic
    always @(negedge clk) begin
        tgt_done      <= (tgt_cnt == 1);
        cs_rd_release <= (tgt_cnt == 1) && !cur_wr;
        tgt_rdata     <= (tgt_cnt == 1) ? exp_rd(cur_addr) : ~exp_rd(cur_addr);
        if (!rst) begin
            core_cycle_busy <= ($urandom % 4 == 0);
            graphics_dma_engine_request    <= ($urandom % 3 == 0);
        end
        if (tgt_cnt != 0)
            tgt_cnt <= tgt_cnt - 1;
        else if (tgt_start === 1'b1) begin
            tgt_cnt <= 1 + $urandom % 4;
            chk(tgt_select, region(cur_addr));
            chk(tgt_write, cur_wr);
            if (cur_wr)
                chk(tgt_wdata, cur_wdata);
        end
        if (ext_transfer_ack_n === 1'b0) begin
            chk(bus_grant_n, 0);
            chk(core_owns_bus, 0);
            chk(ext_data_oe, !cur_wr && region(cur_addr) != ebma_pkg::TGT_NONE);
            chk(graphics_dma_engine_grant, 0);
        end
        if (bus_grant_n === 1'b0)
            chk(bus_float, 1);
    end

    initial begin
        logic [31:0] r;
        logic [15:0] rd;
        logic        ackh, ok, unm;
        int          k, n;
        rst = 1;
        sw_clear_illegal = 0;
        cur_addr = '0;
        cur_wr = 0;
        cur_wdata = '0;
        void'($urandom(19));
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 0;
        chk(bus_grant_n, 1);
        chk(ext_transfer_ack_n, 1);
        chk(core_owns_bus, 1);
        for (k = 0; k < 40; k++) begin
            r = $urandom;
            cur_addr = (k == 0) ? 25'h0000000 : (k == 1) ? 25'h0bffffe : (k == 2) ? 25'h1000000 : r[24:0];
            r = $urandom;
            cur_wr = r[1];
            cur_wdata = r[31:16];
            unm = (region(cur_addr) == ebma_pkg::TGT_NONE);
            u_ebma_ext_master.run(cur_wr, cur_addr, cur_wdata, r[0], unm ? 3 : 0, rd, ackh, ok);
            chk(ok, 1);
            n = 0;
            while (bus_grant_n !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk(bus_grant_n, 1);
            chk(core_owns_bus, 1);
            if (unm) begin
                chk(ackh, 0);
                chk(ext_illegal_addr_flag, 1);
                chk(event_level, ebma_pkg::EVENT_LEVEL);
                sw_clear_illegal = 1;
                @(negedge clk) sw_clear_illegal = 0;
                @(negedge clk);
                chk(ext_illegal_addr_flag, 0);
                chk(event_level, 0);
            end else begin
                if (!cur_wr)
                    chk(rd, exp_rd(cur_addr));
                chk(ext_illegal_addr_flag, 0);
            end
        end
        stop_test;
    end
endmodule
